//--- src/amw_pkg.sv
`default_nettype none
package amw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  // Timing figures in ns, startup in ms
  localparam int unsigned T_CYCLE_NS = 35;
  localparam int unsigned T_ADDR_SETUP_NS = 0;
  localparam int unsigned T_ADDR_END_GHI_NS = 18;
  localparam int unsigned T_ADDR_END_GLO_NS = 20;
  localparam int unsigned T_PULSE_NS = 15;
  localparam int unsigned T_DATA_SETUP_NS = 10;
  localparam int unsigned T_DATA_HOLD_NS = 0;
  localparam int unsigned T_HIGH_HOLD_NS = 2;
  localparam int unsigned T_RECOVERY_NS = 12;
  localparam int unsigned T_STARTUP_MS = 2;
  function automatic int unsigned ns_to_cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_min
  // Strobe low time covers pulse width, address-to-end and data setup
  localparam int unsigned PULSE_NS_MAX =
    (T_PULSE_NS > T_ADDR_END_GLO_NS) ? T_PULSE_NS : T_ADDR_END_GLO_NS;
  localparam int unsigned PULSE_NS =
    (PULSE_NS_MAX > T_DATA_SETUP_NS) ? PULSE_NS_MAX : T_DATA_SETUP_NS;
  localparam int unsigned PULSE_CYC = ns_to_cyc_min(PULSE_NS);
  localparam int unsigned SETUP_CYC = ns_to_cyc_min(T_ADDR_SETUP_NS);
  localparam int unsigned RECOV_HI_NS =
    (T_RECOVERY_NS > T_HIGH_HOLD_NS) ? T_RECOVERY_NS : T_HIGH_HOLD_NS;
  localparam int unsigned RECOV_CYC = ns_to_cyc_min(RECOV_HI_NS);
  localparam int unsigned CYCLE_CYC = ns_to_cyc_min(T_CYCLE_NS);
  localparam int unsigned HOLD_CYC = ns_to_cyc_min(T_DATA_HOLD_NS);
  localparam int unsigned STARTUP_CYC_DEF = (T_STARTUP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned STARTUP_W = 20;
  typedef enum logic [4:0] {
    AMW_POWERUP = 5'h01,
    AMW_IDLE    = 5'h02,
    AMW_SETUP   = 5'h04,
    AMW_PULSE   = 5'h08,
    AMW_RECOVER = 5'h10
  } amw_state_e;
endpackage : amw_pkg
`default_nettype wire

//--- src/amw_delay.sv
`default_nettype none
// Loadable down counter, done when zero
module amw_delay
  import amw_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic zero = (cnt_q == '0);
  assign cnt_d = load_i ? value_i : (zero ? cnt_q : cnt_q - W'(1));
  assign done_o = zero;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : amw_delay
`default_nettype wire

//--- src/amw_host.sv
`default_nettype none
// Function
// RULE1: Write window is chip select and strobe overlap
// RULE2: Device keeps data high-impedance, output enable late
// RULE3: Device hi-Z when select falls with strobe
// RULE4: Device hi-Z when select rises with strobe
// RULE5: Raised strobe, select, byte selects stay high
// RULE6: Byte selects asserted together without skew
// RULE7: Chip select falling edges spaced 35 ns
// RULE8: Write cycle lasts at least 35 ns
// RULE9: Address valid before write, held 18/20 ns
// RULE10: Write strobe low at least 15 ns
// RULE11: Data valid 10 ns before end, held
// RULE12: Device releases data within 12 ns
// RULE13: Device re-drives no sooner than 3 ns
// RULE14: Chip select low 15 ns before end
// RULE15: Wait 2 ms startup, controls held high
// RULE16: Memory holds 131072 words of 16 bits
// RULE17: Only selected byte lanes commit; first rise ends
// RULE18: Address held through write recovery
module amw_host
  import amw_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic REQ_VALID_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_DATA_I,
  input wire logic [1:0] REQ_BE_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  output logic CHIP_SEL_N_O,
  output logic WR_STROBE_N_O,
  output logic OUT_EN_N_O,
  output logic LOW_HALF_N_O,
  output logic UPR_HALF_N_O,
  output logic [BYTE_W-1:0] DAT_LO_O,
  output logic [BYTE_W-1:0] DAT_HI_O,
  output logic DAT_LO_OE_O,
  output logic DAT_HI_OE_O
);
  amw_state_e state_q, state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [1:0] be_q;
  logic ready_q, done_q;
  logic cs_n_q, we_n_q, lo_n_q, hi_n_q, oe_lo_q, oe_hi_q;
  logic [STARTUP_W-1:0] boot_q;
  logic phase_load;
  logic [CNT_W-1:0] phase_val;
  logic phase_done;
  logic cyc_done;
  logic oe_n_q;
  // True when a one-hot state code equals the wanted state
  function automatic logic state_is(input amw_state_e s, input amw_state_e t);
    return (s == t);
  endfunction : state_is
  // Lane strobe: phase active and lane enabled
  function automatic logic lane_on(input logic phase, input logic en);
    return phase & en;
  endfunction : lane_on
  wire logic boot_done = (boot_q == STARTUP_W'(0));
  wire logic req_take = (state_q == AMW_IDLE) & REQ_VALID_I & (REQ_BE_I != 2'b00);
  // Request goes ahead once the cycle spacing has run out
  wire logic take_go = req_take & cyc_done;
  // Next-state decodes shared by the pin registers
  wire logic pulse_nx = state_is(state_d, AMW_PULSE);
  wire logic drive_nx = pulse_nx | state_is(state_d, AMW_RECOVER);
  wire logic idle_nx = state_is(state_d, AMW_IDLE);
  wire logic latch_go = state_is(state_q, AMW_IDLE) & state_is(state_d, AMW_SETUP);
  wire logic end_go = state_is(state_q, AMW_PULSE) & phase_done;
  // Chip select falls on this edge and starts the cycle timer
  wire logic cs_fall = state_is(state_q, AMW_SETUP) & pulse_nx;
  // Lane decodes for byte selects and data drivers
  wire logic lo_on_nx = lane_on(pulse_nx, be_q[0]);
  wire logic hi_on_nx = lane_on(pulse_nx, be_q[1]);
  wire logic lo_drv_nx = lane_on(drive_nx, be_q[0]);
  wire logic hi_drv_nx = lane_on(drive_nx, be_q[1]);
  // Phase timer: setup, pulse and recovery lengths
  amw_delay #(.W(CNT_W)) u_phase (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .load_i(phase_load),
    .value_i(phase_val),
    .done_o(phase_done)
  );
  // Cycle timer from chip select fall to next fall
  amw_delay #(.W(CNT_W)) u_cycle (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .load_i(cs_fall), // RULE7
    .value_i(CNT_W'(CYCLE_CYC - 1)),
    .done_o(cyc_done)
  );
  always_comb begin
    state_d = state_q;
    phase_load = 1'b0;
    phase_val = '0;
    case (state_q)
      AMW_POWERUP: begin
        if (boot_done) state_d = AMW_IDLE; // RULE15
      end
      AMW_IDLE: begin
        if (take_go) begin // RULE7
          state_d = AMW_SETUP;
          phase_load = 1'b1;
          phase_val = CNT_W'(SETUP_CYC - 1); // RULE9
        end
      end
      AMW_SETUP: begin
        if (phase_done) begin
          state_d = AMW_PULSE;
          phase_load = 1'b1;
          phase_val = CNT_W'(PULSE_CYC - 1); // RULE10 RULE14 RULE11
        end
      end
      AMW_PULSE: begin
        if (phase_done) begin
          state_d = AMW_RECOVER;
          phase_load = 1'b1;
          phase_val = CNT_W'(RECOV_CYC + HOLD_CYC - 1); // RULE18 RULE5
        end
      end
      AMW_RECOVER: begin
        if (phase_done && cyc_done) state_d = AMW_IDLE; // RULE8
      end
      default: state_d = AMW_POWERUP;
    endcase
  end
  // Startup wait: controls stay high until it runs out
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      boot_q <= STARTUP_W'(STARTUP_CYC);
    end else if (!boot_done) begin
      boot_q <= boot_q - STARTUP_W'(1);
    end
  end
  // State register
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= AMW_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end
  // Request latch: address, data and lanes hold until the next take
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      addr_q <= '0;
      data_q <= '0;
      be_q <= 2'b00;
    end else if (latch_go) begin
      addr_q <= REQ_ADDR_I; // RULE9 RULE16
      data_q <= REQ_DATA_I;
      be_q <= REQ_BE_I;
    end
  end
  // Control strobes fall and rise on one edge, so the window is their overlap
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else begin
      cs_n_q <= ~pulse_nx; // RULE1
      we_n_q <= ~pulse_nx; // RULE1 RULE2 RULE3 RULE4
    end
  end
  // Byte selects share the strobe edge: no skew between lanes
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lo_n_q <= 1'b1;
      hi_n_q <= 1'b1;
    end else begin
      lo_n_q <= ~lo_on_nx; // RULE17 RULE6
      hi_n_q <= ~hi_on_nx; // RULE17 RULE6
    end
  end
  // Lane drivers stay on through pulse and recovery for data hold
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      oe_lo_q <= 1'b0;
      oe_hi_q <= 1'b0;
    end else begin
      oe_lo_q <= lo_drv_nx; // RULE11
      oe_hi_q <= hi_drv_nx; // RULE11
    end
  end
  // Output enable held off: a write-only host never contends on data
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= 1'b1; // RULE2
    end
  end
  // Handshake flags
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ready_q <= idle_nx;
      done_q <= end_go;
    end
  end
  // Byte enables latch with address; selects use be_q of next state
  assign REQ_READY_O = ready_q;
  assign DONE_O = done_q;
  assign MEM_ADDR_O = addr_q;
  assign CHIP_SEL_N_O = cs_n_q;
  assign WR_STROBE_N_O = we_n_q;
  assign OUT_EN_N_O = oe_n_q; // RULE2
  assign LOW_HALF_N_O = lo_n_q;
  assign UPR_HALF_N_O = hi_n_q;
  assign DAT_LO_O = data_q[BYTE_W-1:0];
  assign DAT_HI_O = data_q[DATA_W-1:BYTE_W];
  assign DAT_LO_OE_O = oe_lo_q;
  assign DAT_HI_OE_O = oe_hi_q;
endmodule : amw_host
`default_nettype wire

//--- test/amw_host_monitor.sv
`default_nettype none
module amw_host_mon
  import amw_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic REQ_VALID_I,
  input wire logic [1:0] REQ_BE_I,
  input wire logic REQ_READY_O,
  input wire logic DONE_O,
  input wire logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic CHIP_SEL_N_O,
  input wire logic WR_STROBE_N_O,
  input wire logic OUT_EN_N_O,
  input wire logic LOW_HALF_N_O,
  input wire logic UPR_HALF_N_O,
  input wire logic [BYTE_W-1:0] DAT_LO_O,
  input wire logic DAT_LO_OE_O,
  input wire logic DAT_HI_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  chk_take_write:
    assert property (REQ_VALID_I && REQ_READY_O && |REQ_BE_I |-> ##[1:3] !WR_STROBE_N_O)
    else $error("write not issued");
  chk_sel_span:
    assert property (!WR_STROBE_N_O |-> !CHIP_SEL_N_O && DAT_LO_OE_O == !LOW_HALF_N_O
      && DAT_HI_OE_O == !UPR_HALF_N_O) else $error("select or lane wrong");
  chk_pulse_end:
    assert property ($fell(WR_STROBE_N_O) |=> $rose(CHIP_SEL_N_O) && DONE_O)
    else $error("pulse end wrong");
  chk_high_hold:
    assert property ($rose(WR_STROBE_N_O) |=> WR_STROBE_N_O && LOW_HALF_N_O && UPR_HALF_N_O)
    else $error("strobe not held high");
  chk_cs_space:
    assert property ($fell(CHIP_SEL_N_O) |=> CHIP_SEL_N_O [*2]) else $error("select too close");
  chk_addr_hold:
    assert property (!WR_STROBE_N_O |-> $stable(MEM_ADDR_O) && $stable(DAT_LO_O))
    else $error("address or data moved");
  chk_recov_hold:
    assert property ($rose(WR_STROBE_N_O) |=> $stable(MEM_ADDR_O)) else $error("no recovery");
  chk_out_off:
    assert property (OUT_EN_N_O) else $error("output enable asserted");
  chk_done_once:
    assert property (DONE_O |=> !DONE_O) else $error("done too long");
  chk_byte_skew:
    assert property (!LOW_HALF_N_O && !UPR_HALF_N_O |-> $fell(LOW_HALF_N_O) == $fell(UPR_HALF_N_O))
    else $error("byte select skew");
endmodule : amw_host_mon
bind amw_host amw_host_mon i_mon (
  .CLK_I(CLK_I),
  .ARST_N_I(ARST_N_I),
  .REQ_VALID_I(REQ_VALID_I),
  .REQ_BE_I(REQ_BE_I),
  .REQ_READY_O(REQ_READY_O),
  .DONE_O(DONE_O),
  .MEM_ADDR_O(MEM_ADDR_O),
  .CHIP_SEL_N_O(CHIP_SEL_N_O),
  .WR_STROBE_N_O(WR_STROBE_N_O),
  .OUT_EN_N_O(OUT_EN_N_O),
  .LOW_HALF_N_O(LOW_HALF_N_O),
  .UPR_HALF_N_O(UPR_HALF_N_O),
  .DAT_LO_O(DAT_LO_O),
  .DAT_LO_OE_O(DAT_LO_OE_O),
  .DAT_HI_OE_O(DAT_HI_OE_O)
);
`default_nettype wire

//--- test/amw_mem_model.sv
`default_nettype none
module amw_mem_model
  import amw_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic lo_n_i,
  input wire logic hi_n_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic drv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire logic win = !cs_n_i && !we_n_i;
  assign drv_o = !cs_n_i && we_n_i && !oe_n_i;
  // Level write: each lane follows the bus while selected in the window
  always @* begin
    if (win && !lo_n_i) mem[addr_i][7:0] = dq_i[7:0];
    if (win && !hi_n_i) mem[addr_i][15:8] = dq_i[15:8];
  end
endmodule : amw_mem_model
`default_nettype wire

//--- test/tb_async_mram_write_cycle.sv
`default_nettype none
module tb_async_mram_write_cycle
  import amw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0;
  logic [ADDR_W-1:0] adr = '0, madr;
  logic [DATA_W-1:0] wd = '0;
  logic [1:0] be = 2'h0;
  logic rdy, done, cs_n, we_n, oe_n, lo_n, hi_n, lo_oe, hi_oe, drv;
  logic [BYTE_W-1:0] dlo, dhi;
  wire [DATA_W-1:0] dq = {hi_oe ? dhi : ~dhi, lo_oe ? dlo : ~dlo};
  int failures = 0, num_checks = 0;
  amw_host #(.STARTUP_CYC(10)) i_dut (.CLK_I(clk), .ARST_N_I(rst_n), .REQ_VALID_I(vld),
    .REQ_ADDR_I(adr), .REQ_DATA_I(wd), .REQ_BE_I(be), .REQ_READY_O(rdy), .DONE_O(done),
    .MEM_ADDR_O(madr), .CHIP_SEL_N_O(cs_n), .WR_STROBE_N_O(we_n), .OUT_EN_N_O(oe_n),
    .LOW_HALF_N_O(lo_n), .UPR_HALF_N_O(hi_n), .DAT_LO_O(dlo), .DAT_HI_O(dhi),
    .DAT_LO_OE_O(lo_oe), .DAT_HI_OE_O(hi_oe));
  amw_mem_model i_mem (.addr_i(madr), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .lo_n_i(lo_n), .hi_n_i(hi_n), .dq_i(dq), .drv_o(drv));
  initial forever #10 clk = ~clk;
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] b);
    int n;
    n = 0;
    @(negedge clk);
    adr = a;
    wd = d;
    be = b;
    vld = 1'b1;
    while (rdy !== 1'b1 && ++n < 40) @(negedge clk);
    @(negedge clk);
    vld = 1'b0;
    chk_bit("busy", 1'b0, rdy);
    n = 0;
    while (done !== 1'b1 && ++n < 10) begin
      chk_bit("bus free", 1'b0, drv);
      @(negedge clk);
    end
    chk_bit("done", 1'b1, done);
    @(negedge clk);
    chk_bit("done once", 1'b0, done);
  endtask : wr
  task automatic t_start;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      chk_bit("idle sel", 1'b1, cs_n);
      chk_bit("idle strobe", 1'b1, we_n);
      @(negedge clk);
      n++;
    end
    chk_bit("startup", 1'b1, n >= 10);
  endtask : t_start
  task automatic t_lanes(input logic [ADDR_W-1:0] a);
    wr(a, 16'hA5C3, 2'h3);
    chk("word", 16'hA5C3, i_mem.mem[a]);
    wr(a, 16'h5A5A, 2'h1);
    chk("lo lane", 16'hA55A, i_mem.mem[a]);
    wr(a, 16'h3C3C, 2'h2);
    chk("hi lane", 16'h3C5A, i_mem.mem[a]);
  endtask : t_lanes
  task automatic t_refuse;
    @(negedge clk);
    be = 2'h0;
    vld = 1'b1;
    repeat (8) begin
      @(negedge clk);
      chk_bit("no write", 1'b1, cs_n);
      chk_bit("still ready", 1'b1, rdy);
    end
    vld = 1'b0;
  endtask : t_refuse
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_start();
    t_lanes(17'h00000);
    t_lanes(17'h1FFFF);
    t_refuse();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_start();
    t_lanes(17'h15555);
    close_out();
  end
  initial begin
    #100us;
    failures++;
    close_out();
  end
endmodule : tb_async_mram_write_cycle
`default_nettype wire
